// *** core/rsc_flash_guard.sv ***
// flash access checker: flags accesses that must end in a flash error reset
// assumes one-cycle request strobes synchronous to clk
`timescale 1ns/10ps
`include "rsc_regs.svh"
module rsc_flash_guard #(
  parameter logic [15:0] RESERVED = `RSC_FLASH_RESERVED
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // access strobes
  input wire logic flashWriteEn,
  input wire logic flashWrReq,
  input wire logic codeRdReq,
  input wire logic fetchReq,
  input wire logic [15:0] flashAddr,
  input wire logic flashSecBlock,
  // supply monitor high, on and selected
  input wire logic supplyOk,
  // registered fault
  output logic fault
);
  import rsc_pkg::*;

  typedef struct packed {
    logic fault;
  } rsc_fg_state_t;

  rsc_fg_state_t s_q;
  rsc_fg_state_t s_d;
  logic flashOp;
  logic high;

  assign flashOp = (flashWrReq && flashWriteEn) || codeRdReq;
  assign high = flashAddr >= RESERVED;

  //////////////////////////////////////////////////////////////////////////////
  // any illegal access raises a one-cycle fault
  always_comb begin
    s_d.fault = (flashOp && high) || (fetchReq && high);
    if (flashOp && flashSecBlock) begin
      s_d.fault = 1'b1;
    end
    if (flashOp && !supplyOk) begin
      s_d.fault = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fault = s_q.fault;

  supply_fault_a: assert property (@(posedge clk) disable iff (!rstN)
    flashOp && !supplyOk |=> fault)
    else $error("flash access with weak supply not faulted");
endmodule

// *** core/rsc_pkg.sv ***
// types shared by the reset source controller modules
// assumes the constants of rsc_regs.svh
package rsc_pkg;

  // sequencer states
  typedef enum logic [0:0] {
    RSC_RUN,
    RSC_HOLD
  } rsc_state_t;

  // reset cause, listed in order of priority
  typedef enum logic [2:0] {
    RSC_CAUSE_SUPPLY,
    RSC_CAUSE_PIN,
    RSC_CAUSE_CLKLOSS,
    RSC_CAUSE_COMP,
    RSC_CAUSE_WDT,
    RSC_CAUSE_FLASH,
    RSC_CAUSE_SW
  } rsc_cause_t;

endpackage

// *** core/rsc_regs.svh ***
// register addresses, field positions, reset values and timing for the reset source controller
// assumes a 20 MHz system clock and an 8-bit special-function register port
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// special-function register addresses
`define RSC_ADDR_SUPPLY_CTRL 8'hFF
`define RSC_ADDR_RESET_CAUSE 8'hEF
`define RSC_ADDR_NONE_DATA 8'h00

// supply_monitor_control fields
`define RSC_SMC_ON_BIT 7
`define RSC_SMC_STAT_BIT 6
`define RSC_SMC_THR_BIT 5
`define RSC_SMC_UNUSED_ZERO 5'h00

// reset_cause_register fields
`define RSC_RC_PIN_BIT 0
`define RSC_RC_SUPPLY_BIT 1
`define RSC_RC_CLKLOSS_BIT 2
`define RSC_RC_WDT_BIT 3
`define RSC_RC_SW_BIT 4
`define RSC_RC_COMP_BIT 5
`define RSC_RC_FLASH_BIT 6

// reset values taken at power-on
`define RSC_SUPPLY_ON_RST 1'b1
`define RSC_THRESH_RST 1'b0
`define RSC_SUPPLY_SEL_RST 1'b1

// timing
`define RSC_CLK_NS 50
`define RSC_HOLD_NS 1000
`define RSC_CLKLOSS_NS 500
`define RSC_WDT_PRESCALE 12
`define RSC_WDT_LIMIT 256
`define RSC_FLASH_RESERVED 16'hFC00

`endif

// *** core/rsc_reset_ctrl.sv ***
// reset source controller: supply monitor control, reset causes, reset sequencing
// assumes an 8-bit special-function register port and inputs synchronous to clk
`timescale 1ns/10ps
`include "rsc_regs.svh"
module rsc_reset_ctrl #(
  parameter int HOLD_CYCLES = (`RSC_HOLD_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS,
  parameter int CLKLOSS_CYCLES = (`RSC_CLKLOSS_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS,
  parameter int WDT_PRESCALE = `RSC_WDT_PRESCALE,
  parameter int WDT_LIMIT = `RSC_WDT_LIMIT,
  parameter logic [15:0] FLASH_RESERVED = `RSC_FLASH_RESERVED
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // special-function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // analog monitors
  input wire logic supplyAbove,
  input wire logic compOut,
  output logic supplyMonOn,
  output logic supplyHighThr,
  // external reset pin, active low
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  // watched system clock
  input wire logic sysClkMon,
  // watchdog service
  input wire logic wdtKick,
  input wire logic wdtDisable,
  // flash access strobes
  input wire logic flashWriteEn,
  input wire logic flashWrReq,
  input wire logic codeRdReq,
  input wire logic fetchReq,
  input wire logic [15:0] flashAddr,
  input wire logic flashSecBlock,
  // system reset to the rest of the chip
  output logic sysReset
);
  import rsc_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    rsc_state_t st;
    logic [HW-1:0] cnt;
    rsc_cause_t cause;
    logic supplyOn;
    logic thresh;
    logic supplySel;
    logic compSel;
    logic clkLossEn;
    logic wdtEn;
    logic [6:0] flags;
    logic [7:0] rdata;
    logic sysRst;
    logic pinOe;
    logic clkMonPrev;
  } rsc_ctrl_state_t;

  rsc_ctrl_state_t s_q;
  rsc_ctrl_state_t s_d;
  logic [1:0] rstSync_q;
  logic rstN;
  logic supplyTrip;
  logic pinTrip;
  logic compTrip;
  logic swForce;
  logic flashFault;
  logic holdActive;
  logic [6:0] causeFlag;

  rsc_tmo_if clkLossIf();
  rsc_tmo_if wdtIf();

  // refuse hold, clock-loss and watchdog settings the counters cannot serve
  if (HOLD_CYCLES < 1 || CLKLOSS_CYCLES < 2 || WDT_PRESCALE < 1 || WDT_LIMIT < 2) begin : g_chk
    $error("rsc_reset_ctrl: timing parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion is immediate, release is clean
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // reset requests from the individual sources
  assign supplyTrip = s_q.supplyOn && s_q.supplySel && !supplyAbove;
  assign pinTrip = !rstPinIn;
  assign compTrip = s_q.compSel && !compOut;
  assign swForce = sfrWr && sfrAddr == `RSC_ADDR_RESET_CAUSE
    && sfrWdata[`RSC_RC_SW_BIT];

  // level sources keep reset asserted for as long as they stay active
  always_comb begin
    unique case (s_q.cause)
      RSC_CAUSE_SUPPLY: holdActive = supplyTrip;
      RSC_CAUSE_PIN: holdActive = pinTrip;
      RSC_CAUSE_COMP: holdActive = compTrip;
      default: holdActive = 1'b0;
    endcase
  end

  // cause flag that is left standing on exit
  always_comb begin
    causeFlag = 7'h00;
    unique case (s_q.cause)
      RSC_CAUSE_SUPPLY: causeFlag[`RSC_RC_SUPPLY_BIT] = 1'b1;
      RSC_CAUSE_PIN: causeFlag[`RSC_RC_PIN_BIT] = 1'b1;
      RSC_CAUSE_CLKLOSS: causeFlag[`RSC_RC_CLKLOSS_BIT] = 1'b1;
      RSC_CAUSE_COMP: causeFlag[`RSC_RC_COMP_BIT] = 1'b1;
      RSC_CAUSE_WDT: causeFlag[`RSC_RC_WDT_BIT] = 1'b1;
      RSC_CAUSE_FLASH: causeFlag[`RSC_RC_FLASH_BIT] = 1'b1;
      RSC_CAUSE_SW: causeFlag[`RSC_RC_SW_BIT] = 1'b1;
      default: causeFlag = 7'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // register access and reset sequencer
  always_comb begin
    s_d = s_q;
    s_d.clkMonPrev = sysClkMon;
    // read data come from a register one cycle after the strobe
    if (sfrRd) begin
      if (sfrAddr == `RSC_ADDR_SUPPLY_CTRL) begin
        s_d.rdata = {s_q.supplyOn, supplyAbove, s_q.thresh, `RSC_SMC_UNUSED_ZERO};
      end else if (sfrAddr == `RSC_ADDR_RESET_CAUSE) begin
        s_d.rdata = {1'b0, s_q.flags};
      end else begin
        s_d.rdata = `RSC_ADDR_NONE_DATA;
      end
    end
    unique case (s_q.st)
      RSC_RUN: begin
        // writes; flags are read-only, low control bits are dropped
        if (sfrWr && sfrAddr == `RSC_ADDR_SUPPLY_CTRL) begin
          s_d.supplyOn = sfrWdata[`RSC_SMC_ON_BIT];
          s_d.thresh = sfrWdata[`RSC_SMC_THR_BIT];
        end
        if (sfrWr && sfrAddr == `RSC_ADDR_RESET_CAUSE) begin
          s_d.supplySel = sfrWdata[`RSC_RC_SUPPLY_BIT];
          s_d.clkLossEn = sfrWdata[`RSC_RC_CLKLOSS_BIT];
          s_d.compSel = sfrWdata[`RSC_RC_COMP_BIT];
        end
        if (wdtDisable) begin
          s_d.wdtEn = 1'b0;
        end
        // one cause wins; supply first so our own pin drive is not taken as a pin reset
        s_d.sysRst = 1'b1;
        s_d.st = RSC_HOLD;
        s_d.cnt = '0;
        s_d.thresh = `RSC_THRESH_RST;
        if (supplyTrip) begin
          s_d.cause = RSC_CAUSE_SUPPLY;
        end else if (pinTrip) begin
          s_d.cause = RSC_CAUSE_PIN;
        end else if (clkLossIf.expire) begin
          s_d.cause = RSC_CAUSE_CLKLOSS;
        end else if (compTrip) begin
          s_d.cause = RSC_CAUSE_COMP;
        end else if (wdtIf.expire) begin
          s_d.cause = RSC_CAUSE_WDT;
        end else if (flashFault) begin
          s_d.cause = RSC_CAUSE_FLASH;
        end else if (swForce) begin
          s_d.cause = RSC_CAUSE_SW;
        end else begin
          s_d.sysRst = 1'b0;
          s_d.st = RSC_RUN;
          s_d.thresh = s_d.thresh;
        end
        if (!s_d.sysRst) begin
          s_d.thresh = (sfrWr && sfrAddr == `RSC_ADDR_SUPPLY_CTRL)
            ? sfrWdata[`RSC_SMC_THR_BIT] : s_q.thresh;
        end
        // only the supply monitor pulls the pin; the rest stay internal
        s_d.pinOe = s_d.sysRst && s_d.cause == RSC_CAUSE_SUPPLY;
      end
      RSC_HOLD: begin
        if (holdActive) begin
          s_d.cnt = '0;
        end else if (s_q.cnt == HW'(HOLD_CYCLES - 1)) begin
          // leave reset: one cause flag stands, comparator, clock-loss and watchdog enables take reset values
          s_d.st = RSC_RUN;
          s_d.sysRst = 1'b0;
          s_d.pinOe = 1'b0;
          s_d.flags = causeFlag;
          s_d.compSel = 1'b0;
          s_d.clkLossEn = 1'b0;
          s_d.wdtEn = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
    endcase
  end

  // power-on counts as a supply reset and drives the pin low until released
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '{st: RSC_HOLD, cnt: '0, cause: RSC_CAUSE_SUPPLY,
        supplyOn: `RSC_SUPPLY_ON_RST, thresh: `RSC_THRESH_RST,
        supplySel: `RSC_SUPPLY_SEL_RST, compSel: 1'b0, clkLossEn: 1'b0,
        wdtEn: 1'b1, flags: 7'h00, rdata: 8'h00, sysRst: 1'b1,
        pinOe: 1'b1, clkMonPrev: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock-loss one-shot: any edge of the watched clock retriggers it
  assign clkLossIf.restart = s_q.sysRst;
  assign clkLossIf.enable = s_q.clkLossEn;
  assign clkLossIf.kick = sysClkMon ^ s_q.clkMonPrev;

  rsc_timeout #(
    .PRESCALE(1),
    .LIMIT(CLKLOSS_CYCLES)
  ) u_clk_loss (
    .clk(clk),
    .rstN(rstN),
    .tmo(clkLossIf.timer)
  );

  // watchdog function, divided by twelve, restarted by every reset
  assign wdtIf.restart = s_q.sysRst;
  assign wdtIf.enable = s_q.wdtEn;
  assign wdtIf.kick = wdtKick;

  rsc_timeout #(
    .PRESCALE(WDT_PRESCALE),
    .LIMIT(WDT_LIMIT)
  ) u_watchdog (
    .clk(clk),
    .rstN(rstN),
    .tmo(wdtIf.timer)
  );

  // flash guard sees the supply monitor as safe only when high, on and selected
  rsc_flash_guard #(
    .RESERVED(FLASH_RESERVED)
  ) u_flash_guard (
    .clk(clk),
    .rstN(rstN),
    .flashWriteEn(flashWriteEn),
    .flashWrReq(flashWrReq),
    .codeRdReq(codeRdReq),
    .fetchReq(fetchReq),
    .flashAddr(flashAddr),
    .flashSecBlock(flashSecBlock),
    .supplyOk(s_q.supplyOn && s_q.thresh && s_q.supplySel),
    .fault(flashFault)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops, rstPinOut tied low; the pin is only ever pulled low
  assign sfrRdata = s_q.rdata;
  assign supplyMonOn = s_q.supplyOn;
  assign supplyHighThr = s_q.thresh;
  assign rstPinOut = 1'b0;
  assign rstPinOe = s_q.pinOe;
  assign sysReset = s_q.sysRst;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  supply_gate_a: assert property (@(posedge clk) disable iff (!rstN)
    s_q.st == RSC_HOLD && s_q.cause == RSC_CAUSE_SUPPLY && $rose(s_q.sysRst)
    |-> $past(s_q.supplyOn) && $past(s_q.supplySel))
    else $error("supply reset without monitor enabled and selected");

  status_live_a: assert property (@(posedge clk) disable iff (!rstN)
    sfrRd && sfrAddr == `RSC_ADDR_SUPPLY_CTRL
    |=> sfrRdata[`RSC_SMC_STAT_BIT] == $past(supplyAbove) && sfrRdata[4:0] == 5'h00)
    else $error("supply status read wrong");

  thresh_low_a: assert property (@(posedge clk) disable iff (!rstN)
    $rose(s_q.sysRst) |-> !s_q.thresh)
    else $error("threshold not returned low on reset");

  pin_hold_a: assert property (@(posedge clk) disable iff (!rstN)
    !rstPinIn && !rstPinOe |=> sysReset)
    else $error("low pin did not hold reset");

  pin_flag_a: assert property (@(posedge clk) disable iff (!rstN)
    $fell(s_q.sysRst) && s_q.cause == RSC_CAUSE_PIN |-> s_q.flags == 7'h01)
    else $error("pin cause flag not alone after pin reset");

  pin_free_a: assert property (@(posedge clk) disable iff (!rstN)
    rstPinOe |-> s_q.cause == RSC_CAUSE_SUPPLY && sysReset)
    else $error("pin driven by an internal reset source");

  comp_hold_a: assert property (@(posedge clk) disable iff (!rstN)
    s_q.compSel && !compOut |=> sysReset)
    else $error("comparator low did not reset");

  sw_force_a: assert property (@(posedge clk) disable iff (!rstN)
    s_q.st == RSC_RUN && swForce && !supplyTrip && !pinTrip && !clkLossIf.expire
    && !compTrip && !wdtIf.expire && !flashFault
    |=> sysReset && s_q.cause == RSC_CAUSE_SW ##[1:300] !sysReset ##0 s_q.flags == 7'h10)
    else $error("software reset not taken or flagged");

  wdt_restart_a: assert property (@(posedge clk) disable iff (!rstN)
    $fell(s_q.sysRst) |-> s_q.wdtEn)
    else $error("watchdog not enabled after reset");
endmodule

// *** core/rsc_timeout.sv ***
// retriggerable one-shot with prescaler: clock-loss detector and watchdog function
// assumes kick and restart are synchronous to clk
`timescale 1ns/10ps
module rsc_timeout #(
  parameter int PRESCALE = 1,
  parameter int LIMIT = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // control and expiry
  rsc_tmo_if.timer tmo
);
  import rsc_pkg::*;

  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam int CW = $clog2(LIMIT);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [CW-1:0] cnt;
    logic expire;
  } rsc_tmo_state_t;

  rsc_tmo_state_t s_q;
  rsc_tmo_state_t s_d;

  // refuse settings the counters cannot hold
  if (PRESCALE < 1 || LIMIT < 2) begin : g_chk
    $error("rsc_timeout: PRESCALE must be >= 1 and LIMIT >= 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // count prescaled ticks; any kick starts the one-shot over
  always_comb begin
    s_d = s_q;
    s_d.expire = 1'b0;
    if (tmo.restart || !tmo.enable || tmo.kick) begin
      s_d.pre = '0;
      s_d.cnt = '0;
    end else if (s_q.pre == PW'(PRESCALE - 1)) begin
      s_d.pre = '0;
      if (s_q.cnt == CW'(LIMIT - 1)) begin
        s_d.cnt = '0;
        s_d.expire = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end else begin
      s_d.pre = s_q.pre + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tmo.expire = s_q.expire;

  // expiry only follows a full count with the timer enabled
  expire_cause_a: assert property (@(posedge clk) disable iff (!rstN)
    s_q.expire |-> $past(tmo.enable) && !$past(tmo.kick) && $past(s_q.cnt) == CW'(LIMIT - 1))
    else $error("timeout expired without a full quiet count");
endmodule

// *** core/rsc_tmo_if.sv ***
// carrier between the sequencer and one retriggerable timeout
// assumes both ends share clk
`timescale 1ns/10ps
interface rsc_tmo_if;
  logic restart;
  logic enable;
  logic kick;
  logic expire;
  modport owner(output restart, output enable, output kick, input expire);
  modport timer(input restart, input enable, input kick, output expire);
endinterface

// *** testbench/rsc_far_side.sv ***
// far-side model: external reset circuit, supply monitor and comparator outputs, watched clock
// assumes scenario controls change at the falling edge of clk
`timescale 1ns/10ps
module rsc_far_side (
  // bench clock
  input wire logic clk,
  // pin drive from the device
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  // scenario controls
  input wire logic extPinLow,
  input wire logic supplyLow,
  input wire logic compLow,
  input wire logic clkStop,
  // levels seen by the device
  output logic rstPinIn,
  output logic supplyAbove,
  output logic compOut,
  output logic sysClkMon
);
  ////////////////////////////////////////////////////////////
  // pin has a pullup, so a released pin reads high, never stale
  assign rstPinIn = !(extPinLow || (rstPinOe && !rstPinOut));
  // analog outputs are plain levels
  assign supplyAbove = !supplyLow;
  assign compOut = !compLow;
  // watched clock stops at whatever level it had, which is the hazard the detector covers
  initial sysClkMon = 1'b0;
  always @(negedge clk) begin
    if (!clkStop) begin
      sysClkMon <= ~sysClkMon;
    end
  end
endmodule

// *** testbench/rsc_reset_ctrl_tb_top.sv ***
// self-checking bench for the reset source controller
// assumes rsc_far_side as the far side; hold and watchdog counts shortened
`timescale 1ns/10ps
`include "rsc_regs.svh"
module rsc_reset_ctrl_tb_top;
  logic clk, nrst, sfrWr, sfrRd, wdtKick, flashWriteEn, flashWrReq, codeRdReq, fetchReq;
  logic flashSecBlock, supplyAbove, compOut, supplyMonOn, supplyHighThr, rstPinIn;
  logic rstPinOut, rstPinOe, sysClkMon, sysReset, extPinLow, supplyLow, compLow, clkStop;
  logic oeAcc, hit, wdtDisable;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, fl;
  logic [15:0] flashAddr;
  int errors, total_checks;
  // illegal flash cases: kind {write, code read, fetch}, address, security block, high threshold
  logic [2:0] kind [5] = '{3'b100, 3'b010, 3'b001, 3'b010, 3'b100};
  logic [15:0] adr [5] = '{16'hFC00, 16'hFFFF, 16'hFC00, 16'h0100, 16'h0100};
  logic sec [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic hi [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  rsc_reset_ctrl #(.HOLD_CYCLES(2), .WDT_LIMIT(4)) dut (.clk(clk), .nrst(nrst),
    .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .supplyAbove(supplyAbove), .compOut(compOut), .supplyMonOn(supplyMonOn),
    .supplyHighThr(supplyHighThr), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut),
    .rstPinOe(rstPinOe), .sysClkMon(sysClkMon), .wdtKick(wdtKick), .wdtDisable(wdtDisable),
    .flashWriteEn(flashWriteEn), .flashWrReq(flashWrReq), .codeRdReq(codeRdReq),
    .fetchReq(fetchReq), .flashAddr(flashAddr), .flashSecBlock(flashSecBlock),
    .sysReset(sysReset));
  rsc_far_side far (.clk(clk), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .extPinLow(extPinLow), .supplyLow(supplyLow), .compLow(compLow), .clkStop(clkStop),
    .rstPinIn(rstPinIn), .supplyAbove(supplyAbove), .compOut(compOut), .sysClkMon(sysClkMon));

  ////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // shared compare, report and closing tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // register port cycles, one strobe cycle each
  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrWr = 1'b1;
    sfrAddr = a;
    sfrWdata = d;
    @(negedge clk);
    sfrWr = 1'b0;
  endtask
  task automatic sfrRead(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfrRd = 1'b1;
    sfrAddr = a;
    @(negedge clk);
    sfrRd = 1'b0;
    @(negedge clk);
    d = sfrRdata;
  endtask

  // reset entry within a bound, then exit with the cause flags read back
  task automatic waitIn(input int lim);
    int n;
    n = 0;
    oeAcc = 1'b0;
    while (sysReset !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    hit = (sysReset === 1'b1);
  endtask
  task automatic waitOut();
    int n;
    n = 0;
    while (sysReset !== 1'b0 && n < 400) begin
      @(negedge clk);
      oeAcc = oeAcc | rstPinOe;
      n++;
    end
    // a reset that never ends counts as a mismatch here
    check("resetExit", sysReset, 8'h00);
    sfrRead(`RSC_ADDR_RESET_CAUSE, fl);
  endtask
  task automatic quiet(input int cyc);
    hit = 1'b0;
    repeat (cyc) begin
      @(negedge clk);
      hit = hit | sysReset;
    end
  endtask
  task automatic flashHit(input int i);
    @(negedge clk);
    {flashWrReq, codeRdReq, fetchReq} = kind[i];
    flashAddr = adr[i];
    flashSecBlock = sec[i];
    @(negedge clk);
    {flashWrReq, codeRdReq, fetchReq} = 3'b000;
    flashSecBlock = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic tPowerOn();
    waitIn(10);
    waitOut();
    check("porFlags", fl, 8'h02);
    check("porPinDrive", oeAcc, 8'h01);
    check("pinDriveLow", rstPinOut, 8'h00);
    sfrRead(`RSC_ADDR_SUPPLY_CTRL, fl);
    check("monCtrlReset", fl, 8'hC0);
    $display("test power-on done");
  endtask
  task automatic tSupply();
    sfrWrite(`RSC_ADDR_SUPPLY_CTRL, 8'h3F);
    check("monOff", supplyMonOn, 8'h00);
    check("thrHigh", supplyHighThr, 8'h01);
    sfrRead(`RSC_ADDR_SUPPLY_CTRL, fl);
    check("monCtrl", fl, 8'h60);
    supplyLow = 1'b1;
    sfrRead(`RSC_ADDR_SUPPLY_CTRL, fl);
    check("liveStatus", fl, 8'h20);
    quiet(20);
    check("offNoReset", hit, 8'h00);
    sfrWrite(`RSC_ADDR_SUPPLY_CTRL, 8'h80);
    waitIn(5);
    check("supplyReset", hit, 8'h01);
    supplyLow = 1'b0;
    waitOut();
    check("supplyFlags", fl, 8'h02);
    sfrWrite(`RSC_ADDR_RESET_CAUSE, 8'h00);
    supplyLow = 1'b1;
    quiet(20);
    check("unselNoReset", hit, 8'h00);
    supplyLow = 1'b0;
    // monitor already on and settled before it is selected again
    sfrWrite(`RSC_ADDR_RESET_CAUSE, 8'h02);
    $display("test supply monitor done");
  endtask
  task automatic tPin();
    extPinLow = 1'b1;
    waitIn(5);
    check("pinReset", hit, 8'h01);
    repeat (5) @(negedge clk);
    extPinLow = 1'b0;
    waitOut();
    check("pinFlags", fl, 8'h01);
    $display("test pin reset done");
  endtask
  task automatic tSoftware();
    sfrWrite(`RSC_ADDR_RESET_CAUSE, 8'h12);
    waitIn(3);
    check("swReset", hit, 8'h01);
    waitOut();
    check("swFlags", fl, 8'h10);
    check("swPinFree", oeAcc, 8'h00);
    $display("test software reset done");
  endtask
  task automatic tComparator();
    // comparator settled low before selection
    compLow = 1'b1;
    quiet(10);
    check("compUnsel", hit, 8'h00);
    sfrWrite(`RSC_ADDR_RESET_CAUSE, 8'h22);
    waitIn(3);
    check("compReset", hit, 8'h01);
    repeat (5) @(negedge clk);
    compLow = 1'b0;
    waitOut();
    check("compFlags", fl, 8'h20);
    check("compPinFree", oeAcc, 8'h00);
    $display("test comparator reset done");
  endtask
  task automatic tClockLoss();
    clkStop = 1'b1;
    quiet(30);
    check("detOff", hit, 8'h00);
    clkStop = 1'b0;
    sfrWrite(`RSC_ADDR_RESET_CAUSE, 8'h06);
    quiet(20);
    check("clkRunning", hit, 8'h00);
    clkStop = 1'b1;
    waitIn(20);
    check("clkLoss", hit, 8'h01);
    clkStop = 1'b0;
    waitOut();
    check("clkFlags", fl, 8'h04);
    check("clkPinFree", oeAcc, 8'h00);
    $display("test clock loss done");
  endtask
  task automatic tWatchdog();
    // disabled watchdog stays quiet; the next reset must turn it back on
    wdtKick = 1'b0;
    wdtDisable = 1'b1;
    quiet(60);
    check("wdtOff", hit, 8'h00);
    wdtDisable = 1'b0;
    sfrWrite(`RSC_ADDR_RESET_CAUSE, 8'h12);
    waitIn(3);
    waitOut();
    quiet(30);
    check("wdtEarly", hit, 8'h00);
    waitIn(100);
    check("wdtReset", hit, 8'h01);
    wdtKick = 1'b1;
    waitOut();
    check("wdtFlags", fl, 8'h08);
    check("wdtPinFree", oeAcc, 8'h00);
    $display("test watchdog done");
  endtask
  task automatic tFlash();
    flashWriteEn = 1'b1;
    sfrWrite(`RSC_ADDR_SUPPLY_CTRL, 8'hA0);
    // legal code read below the reserved region with a strong supply
    codeRdReq = 1'b1;
    flashAddr = 16'h0100;
    @(negedge clk);
    codeRdReq = 1'b0;
    quiet(3);
    check("flashLegal", hit, 8'h00);
    for (int i = 0; i < 5; i++) begin
      sfrWrite(`RSC_ADDR_SUPPLY_CTRL, hi[i] ? 8'hA0 : 8'h80);
      flashHit(i);
      waitIn(5);
      check("flashReset", hit, 8'h01);
      waitOut();
      check("flashFlags", fl, 8'h40);
      check("flashPinFree", oeAcc, 8'h00);
      check("thrLowAfter", supplyHighThr, 8'h00);
    end
    flashWriteEn = 1'b0;
    $display("test flash error done");
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence, inputs driven at the falling edge
  initial begin
    {nrst, sfrWr, sfrRd, flashWriteEn, flashWrReq, codeRdReq, fetchReq} = 7'h00;
    {flashSecBlock, extPinLow, supplyLow, compLow, clkStop, wdtDisable} = 6'h00;
    wdtKick = 1'b1;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    flashAddr = 16'h0000;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    tPowerOn();
    tSupply();
    tPin();
    tSoftware();
    tComparator();
    tClockLoss();
    tWatchdog();
    tFlash();
    results();
  end

  // the whole run needs well under 3000 cycles; ten times that means a hang
  initial begin
    #(30000 * 50);
    errors++;
    results();
  end
endmodule
